// ### design/dcw_regs.svh
`ifndef DCW_REGS_SVH
`define DCW_REGS_SVH
// register map (byte addresses)
`define DCW_CTRL_OFF        12'h000
`define DCW_STATUS_OFF      12'h004
`define DCW_WAKE_CLR_OFF    12'h008
// control register fields
`define DCW_CTRL_CH1_MODE   0
`define DCW_CTRL_CH2_MODE   1
`define DCW_CTRL_RESET      32'h0000_0000
// status register fields, ch2 at +8
`define DCW_ST_MODE_LSB     0
`define DCW_ST_WAKE         2
`define DCW_ST_TXTO         3
`define DCW_ST_BUSCL        4
`define DCW_ST_CH_STRIDE    8
// timing in ns, figures chosen for this block
`define DCW_CLK_NS          20
`define DCW_FLTR_NS         1000
`define DCW_DOM_NS          500
`define DCW_REC_NS          500
`define DCW_TO_NS           1000000
`define DCW_TXDOM_NS        2000000
// least times round up, longest times round down
`define DCW_FLTR_CYC        ((`DCW_FLTR_NS + `DCW_CLK_NS - 1) / `DCW_CLK_NS)
`define DCW_DOM_CYC         ((`DCW_DOM_NS + `DCW_CLK_NS - 1) / `DCW_CLK_NS)
`define DCW_REC_CYC         ((`DCW_REC_NS + `DCW_CLK_NS - 1) / `DCW_CLK_NS)
`define DCW_TO_CYC          (`DCW_TO_NS / `DCW_CLK_NS)
`define DCW_TXDOM_CYC       (`DCW_TXDOM_NS / `DCW_CLK_NS)
`endif

// ### design/dcw_pkg.sv
package dcw_pkg;
    typedef enum logic [1:0] {DCW_OFF, DCW_STANDBY, DCW_NORMAL} dcw_mode_e;
    typedef enum logic [1:0] {DCW_W_IDLE, DCW_W_DOM1, DCW_W_REC, DCW_W_DOM2} dcw_wake_e;
endpackage : dcw_pkg

// ### design/dcw_channel.sv
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "dcw_regs.svh"
module dcw_channel #(
    parameter int FLTR_CYC  = `DCW_FLTR_CYC,
    parameter int DOM_CYC   = `DCW_DOM_CYC,
    parameter int REC_CYC   = `DCW_REC_CYC,
    parameter int TO_CYC    = `DCW_TO_CYC,
    parameter int TXDOM_CYC = `DCW_TXDOM_CYC
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // mode
    input  wire dcw_pkg::dcw_mode_e mode,
    input  wire logic              wake_clr,
    // host side
    input  wire logic              transmit_in,
    output logic                   receive_out,
    // line side, bus_dom_in is the synchronised differential comparator
    input  wire logic              bus_dom_in,
    output logic                   drive_dom,
    output logic                   bias_half,
    output logic                   bias_gnd,
    // status
    output logic                   wake_flag,
    output logic                   txdom_flag,
    output logic                   busclamp_flag
);
    localparam int CW = 32;
    logic [CW-1:0]     filt_cnt_reg;
    logic              filt_reg;
    logic              wake_reg;
    dcw_pkg::dcw_wake_e wst_reg;
    logic [CW-1:0]     ph_cnt_reg;
    logic [CW-1:0]     to_cnt_reg;
    logic [CW-1:0]     tx_cnt_reg;
    logic              txto_reg;
    logic              clamp_reg;
    logic              normal_q_reg;
    logic              stby;
    logic              norm;

    assign stby = (mode == dcw_pkg::DCW_STANDBY);
    assign norm = (mode == dcw_pkg::DCW_NORMAL);

    // low-power receiver filter; new level accepted only after FLTR_CYC stable
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            filt_cnt_reg <= '0;
            filt_reg     <= 1'b0;
        end
        else if (mode == dcw_pkg::DCW_OFF)
        begin
            // receiver unpowered: a level seen before off must not seed a new pattern
            filt_cnt_reg <= '0;
            filt_reg     <= 1'b0;
        end
        else if (bus_dom_in == filt_reg)
        begin
            filt_cnt_reg <= '0;
        end
        else if (filt_cnt_reg >= CW'(FLTR_CYC - 1))
        begin
            filt_reg     <= bus_dom_in;
            filt_cnt_reg <= '0;
        end
        else
        begin
            filt_cnt_reg <= filt_cnt_reg + 1'b1;
        end
    end

    // wake pattern recogniser on the filtered bus
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wst_reg    <= dcw_pkg::DCW_W_IDLE;
            ph_cnt_reg <= '0;
            to_cnt_reg <= '0;
        end
        else if (!stby || (wst_reg != dcw_pkg::DCW_W_IDLE && to_cnt_reg >= CW'(TO_CYC - 1)))
        begin
            wst_reg    <= dcw_pkg::DCW_W_IDLE;
            ph_cnt_reg <= '0;
            to_cnt_reg <= '0;
        end
        else
        begin
            unique case (wst_reg)
                dcw_pkg::DCW_W_IDLE:
                begin
                    to_cnt_reg <= '0;
                    ph_cnt_reg <= '0;
                    if (filt_reg)
                        wst_reg <= dcw_pkg::DCW_W_DOM1;
                end
                dcw_pkg::DCW_W_DOM1:
                begin
                    to_cnt_reg <= to_cnt_reg + 1'b1;
                    if (filt_reg)
                        ph_cnt_reg <= ph_cnt_reg + 1'b1;
                    else if (ph_cnt_reg >= CW'(DOM_CYC - 1))
                    begin
                        wst_reg    <= dcw_pkg::DCW_W_REC;
                        ph_cnt_reg <= '0;
                    end
                    else
                        wst_reg <= dcw_pkg::DCW_W_IDLE;
                end
                dcw_pkg::DCW_W_REC:
                begin
                    to_cnt_reg <= to_cnt_reg + 1'b1;
                    if (!filt_reg)
                        ph_cnt_reg <= ph_cnt_reg + 1'b1;
                    else if (ph_cnt_reg >= CW'(REC_CYC - 1))
                    begin
                        wst_reg    <= dcw_pkg::DCW_W_DOM2;
                        ph_cnt_reg <= '0;
                    end
                    else
                    begin
                        wst_reg    <= dcw_pkg::DCW_W_DOM1; // short gap: restart from this dominant
                        ph_cnt_reg <= '0;
                        to_cnt_reg <= '0;
                    end
                end
                dcw_pkg::DCW_W_DOM2:
                begin
                    to_cnt_reg <= to_cnt_reg + 1'b1;
                    if (!filt_reg)
                    begin
                        wst_reg    <= dcw_pkg::DCW_W_REC;
                        ph_cnt_reg <= '0;
                    end
                    else if (ph_cnt_reg >= CW'(DOM_CYC - 1))
                        wst_reg <= dcw_pkg::DCW_W_IDLE;
                    else
                        ph_cnt_reg <= ph_cnt_reg + 1'b1;
                end
            endcase
        end
    end

    logic wake_hit;
    assign wake_hit = stby && wst_reg == dcw_pkg::DCW_W_DOM2 && filt_reg
                      && ph_cnt_reg >= CW'(DOM_CYC - 1)
                      && to_cnt_reg < CW'(TO_CYC - 1);

    // wake flag: set wins over a software clear; leaving standby drops it
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            wake_reg <= 1'b0;
        else if (wake_hit)
            wake_reg <= 1'b1;
        else if (!stby || wake_clr)
            wake_reg <= 1'b0;
    end

    // transmit dominant timeout and bus clamp guard in normal
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_cnt_reg   <= '0;
            txto_reg     <= 1'b0;
            clamp_reg    <= 1'b0;
            normal_q_reg <= 1'b0;
        end
        else
        begin
            normal_q_reg <= norm;
            if (!norm || transmit_in)
            begin
                tx_cnt_reg <= '0;
                txto_reg   <= 1'b0;
            end
            else if (tx_cnt_reg >= CW'(TXDOM_CYC - 1))
                txto_reg <= 1'b1;
            else
                tx_cnt_reg <= tx_cnt_reg + 1'b1;
            // on normal entry with bus dominant, hold driver until bus recessive
            if (!norm || !bus_dom_in)
                clamp_reg <= 1'b0;
            else if (!normal_q_reg)
                clamp_reg <= 1'b1;
        end
    end

    // covers the entry cycle too, before the clamp flop has caught up
    logic clamp_now;
    assign clamp_now = clamp_reg || (!normal_q_reg && bus_dom_in);

    always_comb
    begin
        drive_dom   = norm && !transmit_in && !txto_reg && !clamp_now;
        bias_half   = norm;
        bias_gnd    = stby;
        if (norm)
            receive_out = !bus_dom_in;
        else if (stby)
            receive_out = wake_reg ? !filt_reg : 1'b1;
        else
            receive_out = 1'b1;
    end

    assign wake_flag     = wake_reg;
    assign txdom_flag    = txto_reg;
    assign busclamp_flag = clamp_reg;

    AST_OFF_QUIET: assert property (@(posedge core_clk) disable iff (!resetn)
        mode == dcw_pkg::DCW_OFF |-> !drive_dom && !bias_half && !bias_gnd && receive_out)
        else $error("channel active while off");
    AST_STBY_HIGH: assert property (@(posedge core_clk) disable iff (!resetn)
        stby && !wake_reg |-> receive_out)
        else $error("receive low before wake");
    AST_STBY_NODRV: assert property (@(posedge core_clk) disable iff (!resetn)
        stby |-> !drive_dom && bias_gnd && !bias_half)
        else $error("driver or bias wrong in standby");
    AST_WAKE_RESET: assert property (@(posedge core_clk) disable iff (!resetn)
        !stby |=> wst_reg == dcw_pkg::DCW_W_IDLE)
        else $error("partial pattern kept outside standby");
    AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (!resetn)
        wst_reg != dcw_pkg::DCW_W_IDLE |-> to_cnt_reg < CW'(TO_CYC))
        else $error("wake pattern beyond timeout");
    sequence s_tx_held;
        norm && !transmit_in && tx_cnt_reg >= CW'(TXDOM_CYC - 1);
    endsequence
    AST_TXDOM: assert property (@(posedge core_clk) disable iff (!resetn)
        s_tx_held ##1 (norm && !transmit_in) |-> !drive_dom)
        else $error("transmit dominant not cut off");
    AST_FILTER: assert property (@(posedge core_clk) disable iff (!resetn)
        $changed(filt_reg) && $past(mode) != dcw_pkg::DCW_OFF
        |-> $past(filt_cnt_reg) >= CW'(FLTR_CYC - 1))
        else $error("filter passed a short phase");
    AST_CLAMP: assert property (@(posedge core_clk) disable iff (!resetn)
        norm && !normal_q_reg && bus_dom_in |=> (norm && bus_dom_in) |-> !drive_dom)
        else $error("clamped bus driven on normal entry");
    AST_CLAMP_ENTRY: assert property (@(posedge core_clk) disable iff (!resetn)
        norm && !normal_q_reg && bus_dom_in |-> !drive_dom)
        else $error("clamped bus driven in the entry cycle");
endmodule : dcw_channel

// ### design/dcw_ctrl.sv
`timescale 1ns/100ps
`include "dcw_regs.svh"
module dcw_ctrl #(
    parameter int TO_CYC    = `DCW_TO_CYC,
    parameter int TXDOM_CYC = `DCW_TXDOM_CYC
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // supply monitors and select pins
    input  wire logic        core_uv,
    input  wire logic        io_uv,
    input  wire logic        ch1_standby_select_n,
    input  wire logic        ch2_standby_select_n,
    // host side
    input  wire logic        ch1_transmit_in,
    input  wire logic        ch2_transmit_in,
    output logic             ch1_receive_out,
    output logic             ch2_receive_out,
    // line side, dominant comparator in, driver and bias controls out
    input  wire logic [1:0]  bus_dom,
    output logic [1:0]       bus_drive_dom,
    output logic [1:0]       bus_bias_half,
    output logic [1:0]       bus_bias_gnd
);
    localparam int NS = 3;
    logic [NS-1:0] sy_reg [0:5];
    logic [5:0]    in_reg;
    logic [31:0]   ctrl_reg;
    dcw_pkg::dcw_mode_e mode [0:1];
    logic [1:0]    sel;
    logic [1:0]    wk;
    logic [1:0]    txf;
    logic [1:0]    clf;
    logic [1:0]    rxo;
    logic [1:0]    wclr;
    logic [5:0]    raw;
    logic          wr;

    // pins pass three flops; accept a change once stages two and three agree
    assign raw = {bus_dom, io_uv, core_uv, ch2_standby_select_n, ch1_standby_select_n};
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_sync
            always_ff @(posedge core_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    sy_reg[g] <= '0;
                    in_reg[g] <= 1'b0;
                end
                else
                begin
                    sy_reg[g] <= {sy_reg[g][1:0], raw[g]};
                    if (sy_reg[g][1] == sy_reg[g][2])
                        in_reg[g] <= sy_reg[g][2];
                end
            end
        end
    endgenerate

    // software may force a channel to standby by clearing its enable bit
    assign sel = {in_reg[1] && ctrl_reg[`DCW_CTRL_CH2_MODE],
                  in_reg[0] && ctrl_reg[`DCW_CTRL_CH1_MODE]};

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (in_reg[3])
                mode[i] = dcw_pkg::DCW_OFF;
            else if (in_reg[2] || !sel[i])
                mode[i] = dcw_pkg::DCW_STANDBY;
            else
                mode[i] = dcw_pkg::DCW_NORMAL;
        end
    end

    AST_OFF_BOTH: assert property (@(posedge core_clk) disable iff (!resetn)
        (mode[0] == dcw_pkg::DCW_OFF) == (mode[1] == dcw_pkg::DCW_OFF))
        else $error("one channel off alone");
    AST_CORE_UV: assert property (@(posedge core_clk) disable iff (!resetn)
        in_reg[2] && !in_reg[3]
        |-> mode[0] == dcw_pkg::DCW_STANDBY && mode[1] == dcw_pkg::DCW_STANDBY)
        else $error("channel not in standby under core undervoltage");

    assign wr   = psel && penable && pwrite;
    assign wclr = (wr && paddr == `DCW_WAKE_CLR_OFF) ? pwdata[1:0] : 2'b00;

    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            dcw_channel #(
                .TO_CYC    (TO_CYC),
                .TXDOM_CYC (TXDOM_CYC)
            ) u_ch (
                .core_clk      (core_clk),
                .resetn        (resetn),
                .mode          (mode[g]),
                .wake_clr      (wclr[g]),
                .transmit_in   (g == 0 ? ch1_transmit_in : ch2_transmit_in),
                .receive_out   (rxo[g]),
                .bus_dom_in    (in_reg[4+g]),
                .drive_dom     (bus_drive_dom[g]),
                .bias_half     (bus_bias_half[g]),
                .bias_gnd      (bus_bias_gnd[g]),
                .wake_flag     (wk[g]),
                .txdom_flag    (txf[g]),
                .busclamp_flag (clf[g])
            );
        end
    endgenerate

    assign ch1_receive_out = rxo[0];
    assign ch2_receive_out = rxo[1];

    // apb: zero wait states, unmapped address answers with slverr
    assign pready  = 1'b1;
    assign pslverr = psel && penable && paddr != `DCW_CTRL_OFF
                     && paddr != `DCW_STATUS_OFF && paddr != `DCW_WAKE_CLR_OFF;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            ctrl_reg <= `DCW_CTRL_RESET;
        else if (wr && paddr == `DCW_CTRL_OFF)
            ctrl_reg <= {30'h0000_0000, pwdata[1:0]};
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                `DCW_CTRL_OFF:   prdata <= ctrl_reg;
                `DCW_STATUS_OFF: prdata <= {19'h0_0000, clf[1], txf[1], wk[1], mode[1],
                                            3'h0, clf[0], txf[0], wk[0], mode[0]};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : dcw_ctrl

// ### tb/dcw_bus_model.sv
`timescale 1ns/100ps
module dcw_bus_model #(
    parameter int LAG = 1
) (
    // clock
    input  wire logic       core_clk,
    // remote nodes and local driver
    input  wire logic [1:0] remote_dom,
    input  wire logic [1:0] drive_dom,
    input  wire logic [1:0] bias_half,
    // differential comparator seen by the transceiver
    output logic [1:0]      bus_dom
);
    logic [1:0] line_now;
    logic [1:0] line_q [0:LAG-1];
    // without normal bias the local driver cannot split the pair, so standby and off are silent
    assign line_now = remote_dom | (drive_dom & bias_half);
    // wire plus comparator delay, LAG raises it to model a slow bus
    always_ff @(posedge core_clk)
    begin
        line_q[0] <= line_now;
        for (int i = 1; i < LAG; i++)
            line_q[i] <= line_q[i-1];
    end
    assign bus_dom = line_q[LAG-1];
endmodule : dcw_bus_model

// ### tb/dual_can_phy_mode_wakeup_ctrl_bench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module dual_can_phy_mode_wakeup_ctrl_bench;
    localparam logic [1:0] OF = dcw_pkg::DCW_OFF;
    localparam logic [1:0] SB = dcw_pkg::DCW_STANDBY;
    localparam logic [1:0] NM = dcw_pkg::DCW_NORMAL;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, err;
    logic        core_uv = 1'b0, io_uv = 1'b0;
    logic        ch1_standby_select_n = 1'b0, ch2_standby_select_n = 1'b0;
    logic        ch1_transmit_in = 1'b1, ch2_transmit_in = 1'b1;
    logic        ch1_receive_out, ch2_receive_out, b;
    logic [1:0]  remote_dom = 2'h0, bus_dom, drive_dom, bias_half, bias_gnd;
    int          num_errors = 0, n_tests = 0;

    always #10 core_clk = ~core_clk;

    dcw_ctrl #(.TO_CYC(200), .TXDOM_CYC(100)) i_dcw_ctrl (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_uv(core_uv), .io_uv(io_uv),
        .ch1_standby_select_n(ch1_standby_select_n),
        .ch2_standby_select_n(ch2_standby_select_n),
        .ch1_transmit_in(ch1_transmit_in), .ch2_transmit_in(ch2_transmit_in),
        .ch1_receive_out(ch1_receive_out), .ch2_receive_out(ch2_receive_out),
        .bus_dom(bus_dom), .bus_drive_dom(drive_dom), .bus_bias_half(bias_half),
        .bus_bias_gnd(bias_gnd));

    dcw_bus_model #(.LAG(1)) i_dcw_bus_model (
        .core_clk(core_clk), .remote_dom(remote_dom), .drive_dom(drive_dom),
        .bias_half(bias_half), .bus_dom(bus_dom));

    function automatic logic [31:0] stv(input logic [1:0] m1, input logic w1,
                                        input logic [1:0] m2, input logic w2);
        return {21'h0, w2, m2, 5'h0, w1, m1};
    endfunction : stv

    task report_and_stop;
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // entered right after a rising edge; leaves one idle cycle behind
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            report_and_stop;
        end
        @(posedge core_clk);
    endtask : apb

    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read", e, rdat)
    endtask : rchk

    // one bus phase from the remote nodes
    task ph(input int c, input logic v, input int n);
        remote_dom[c] <= v;
        cyc(n);
    endtask : ph

    initial
    begin
        void'($urandom(32'h18b9ef42));
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        cyc(8);
        `CHK("rx", 2'b11, {ch2_receive_out, ch1_receive_out})
        `CHK("bias", 6'h30, {bias_gnd, bias_half, drive_dom})
        rchk(12'h004, stv(SB, 1'b0, SB, 1'b0));
        rchk(12'h000, 32'h0);
        rchk(12'h00c, 32'h0);
        `CHK("slverr", 1'b1, err)
        // a short glitch and a pattern that runs past the timeout
        ph(0, 1'b1, 20);
        ph(0, 1'b0, 60);
        `CHK("rx1", 1'b1, ch1_receive_out)
        ph(0, 1'b1, 70);
        ph(0, 1'b0, 250);
        ph(0, 1'b1, 70);
        ph(0, 1'b0, 70);
        rchk(12'h004, stv(SB, 1'b0, SB, 1'b0));
        // let the leftover partial pattern time out so the next one starts fresh
        cyc(250);
        // full pattern, random lengths for the first dominant and recessive phases
        ph(0, 1'b1, 60 + $urandom_range(10));
        `CHK("rx1", 1'b1, ch1_receive_out)
        ph(0, 1'b0, 60 + $urandom_range(10));
        // second dominant must outlast filter delay plus minimum dominant time
        ph(0, 1'b1, 90);
        `CHK("rx1", 1'b0, ch1_receive_out)
        ph(0, 1'b0, 10);
        `CHK("rx1", 1'b0, ch1_receive_out)
        ph(0, 1'b0, 60);
        `CHK("rx1", 1'b1, ch1_receive_out)
        rchk(12'h004, stv(SB, 1'b1, SB, 1'b0));
        apb(1'b1, 12'h008, 32'h1);
        rchk(12'h004, stv(SB, 1'b0, SB, 1'b0));
        // ch2 goes normal in mid-pattern, ch1 stays put
        apb(1'b1, 12'h000, 32'h3);
        rchk(12'h000, 32'h3);
        ph(1, 1'b1, 70);
        ph(1, 1'b0, 60);
        ch2_standby_select_n <= 1'b1;
        cyc(8);
        `CHK("bias", 4'b0110, {bias_gnd, bias_half})
        ch2_standby_select_n <= 1'b0;
        cyc(8);
        ph(1, 1'b1, 90);
        `CHK("rx2", 1'b1, ch2_receive_out)
        ph(1, 1'b0, 70);
        // io undervoltage in mid-pattern
        ph(0, 1'b1, 70);
        io_uv <= 1'b1;
        cyc(6);
        `CHK("off", 6'h00, {bias_gnd, bias_half, drive_dom})
        rchk(12'h004, stv(OF, 1'b0, OF, 1'b0));
        io_uv <= 1'b0;
        cyc(6);
        `CHK("bias", 4'b1100, {bias_gnd, bias_half})
        ph(0, 1'b0, 60);
        ph(0, 1'b1, 90);
        `CHK("rx1", 1'b1, ch1_receive_out)
        ph(0, 1'b0, 70);
        // core undervoltage overrides both selects
        ch1_standby_select_n <= 1'b1;
        ch2_standby_select_n <= 1'b1;
        cyc(8);
        rchk(12'h004, stv(NM, 1'b0, NM, 1'b0));
        core_uv <= 1'b1;
        cyc(8);
        `CHK("bias", 4'b1100, {bias_gnd, bias_half})
        rchk(12'h004, stv(SB, 1'b0, SB, 1'b0));
        core_uv <= 1'b0;
        cyc(8);
        `CHK("bias", 4'b0011, {bias_gnd, bias_half})
        // random traffic, dominant runs kept short
        repeat (20)
        begin
            b = 1'($urandom_range(1));
            ch1_transmit_in <= b;
            ch2_transmit_in <= ~b;
            cyc(12);
            `CHK("drive", {b, ~b}, drive_dom)
            `CHK("rx", {~b, b}, {ch2_receive_out, ch1_receive_out})
            ch1_transmit_in <= 1'b1;
            ch2_transmit_in <= 1'b1;
            cyc(12);
        end
        // transmit held dominant, per channel
        ch1_transmit_in <= 1'b0;
        cyc(60);
        ch2_transmit_in <= 1'b0;
        cyc(70);
        `CHK("drive", 2'b10, drive_dom)
        apb(1'b0, 12'h004, 32'h0);
        `CHK("txdom", 2'b01, {rdat[11], rdat[3]})
        ch1_transmit_in <= 1'b1;
        ch2_transmit_in <= 1'b1;
        cyc(8);
        // normal entry onto a bus clamped dominant
        ch1_standby_select_n <= 1'b0;
        cyc(8);
        remote_dom[0] <= 1'b1;
        ch1_transmit_in <= 1'b0;
        cyc(8);
        ch1_standby_select_n <= 1'b1;
        cyc(20);
        `CHK("drive1", 1'b0, drive_dom[0])
        apb(1'b0, 12'h004, 32'h0);
        `CHK("clamp", 1'b1, rdat[4])
        remote_dom[0] <= 1'b0;
        cyc(12);
        `CHK("drive1", 1'b1, drive_dom[0])
        ch1_transmit_in <= 1'b1;
        cyc(4);
        report_and_stop;
    end
endmodule : dual_can_phy_mode_wakeup_ctrl_bench
